// *** design/rps_regs.svh ***
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// clock and hold timing
`define RPS_CLK_PERIOD_NS 8
`define RPS_HOLD_NS       1000
`define RPS_HOLD_CYCLES   ((`RPS_HOLD_NS + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)
`define RPS_CNT_W         8

// boot address of the first prefetch
`define RPS_BOOT_ADDR     24'hFFFFF0

// boot mode strap codes
`define RPS_BOOT_PCI      2'h0
`define RPS_BOOT_LOCAL    2'h1
`define RPS_BOOT_ISA      2'h2
`define RPS_BOOT_PCMCIA   2'h3

// pci clock divide ratio strap codes
`define RPS_RATIO_DIV2    2'h0
`define RPS_RATIO_DIV3    2'h1
`define RPS_RATIO_DIV4    2'h2

`endif

// *** design/rps_pkg.sv ***
package rps_pkg;

  typedef enum logic [4:0] {
    PH_IN_RESET = 5'h01,
    PH_HOLD     = 5'h02,
    PH_INIT     = 5'h04,
    PH_FETCH    = 5'h08,
    PH_RUN      = 5'h10
  } rps_phase_e;

  typedef enum logic [1:0] {
    BUS_PCI   = 2'h0,
    BUS_ISA   = 2'h1,
    BUS_LOCAL = 2'h2
  } rps_bus_e;

  // pin levels; _n fields are active low
  typedef struct packed {
    logic       isa_side_select;
    logic [3:0] drive_select;   // {secondary_b, secondary_a, primary_b, primary_a}
    logic [1:0] io_read_n;      // {secondary, primary}
    logic [1:0] io_write_n;     // {secondary, primary}
    logic [3:0] isa_cmd_n;      // {memr, memw, ior, iow}
    logic [3:0] flash_n;        // {flash1_low, flash1_high, flash1, flash0_low}
  } rps_pins_s;

endpackage

// *** design/rps_clkgen.sv ***
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_clkgen (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // straps already captured
  input  wire logic       mem_sync_in,
  input  wire logic [1:0] ratio_in,
  // independent memory clock source
  input  wire logic       mem_clk_in,
  // clock outputs
  output logic            memory_clock_out,
  output logic            pci_clock_output_out
);
  import rps_pkg::*;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  function automatic logic [2:0] ratio_div(input logic [1:0] r);
    if (r == `RPS_RATIO_DIV2) begin
      ratio_div = 3'h2;
    end else if (r == `RPS_RATIO_DIV4) begin
      ratio_div = 3'h4;
    end else begin
      ratio_div = 3'h3;
    end
  endfunction

  logic [2:0] div;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       pci_ff;
  logic       nxt_pci;

  assign div = ratio_div(ratio_in);

  always_comb begin
    nxt_cnt = (cnt_ff >= div - 3'h1) ? 3'h0 : cnt_ff + 3'h1;
    nxt_pci = nxt_cnt < (div >> 1);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_ff <= 3'h0;
      pci_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pci_ff <= nxt_pci;
    end
  end

  assign pci_clock_output_out = pci_ff;
  // select is a captured strap, steady outside input reset
  assign memory_clock_out = mem_sync_in ? clk_in : mem_clk_in;

  a_pci_div_three: assert property (
    ($rose(pci_ff) && div == 3'h3) ##1 ($stable(ratio_in) [*3]) |-> $rose(pci_ff))
    else $error("pci clock not divided by three");

endmodule

// *** design/rps_top.sv ***
`timescale 1ns/100ps
`include "rps_regs.svh"

module rps_top (
  // clock and reset
  input  wire logic               REF_CLK_IN,
  input  wire logic               SRST_IN,
  // reset pin, straps and memory clock
  input  wire logic               RESET_REQUEST_N_IN,
  input  wire logic [1:0]         BOOT_MODE_IN,
  input  wire logic               MEM_SYNC_STRAP_IN,
  input  wire logic [1:0]         PCI_RATIO_STRAP_IN,
  input  wire logic               MEM_CLOCK_IN,
  // memory init handshake
  output logic                    MEM_INIT_REQ_OUT,
  input  wire logic               MEM_INIT_DONE_IN,
  // first prefetch handshake
  output logic                    PREFETCH_REQ_OUT,
  output rps_pkg::rps_bus_e       PREFETCH_BUS_OUT,
  output logic [23:0]             PREFETCH_ADDR_OUT,
  input  wire logic               PREFETCH_ACK_IN,
  // reset and pins
  output logic                    SYSTEM_RESET_N_OUT,
  output rps_pkg::rps_pins_s      PINS_OUT,
  // clocks
  output logic                    MEMORY_CLOCK_OUT,
  output logic                    PCI_CLOCK_OUTPUT_OUT
);
  import rps_pkg::*;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  function automatic rps_bus_e boot_bus(input logic [1:0] mode);
    if (mode == `RPS_BOOT_LOCAL) begin
      boot_bus = BUS_LOCAL;
    end else if (mode == `RPS_BOOT_ISA || mode == `RPS_BOOT_PCMCIA) begin
      boot_bus = BUS_ISA;
    end else begin
      boot_bus = BUS_PCI;
    end
  endfunction

  // pin synchronisers
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic       req_n;
  logic [1:0] boot_pin;
  logic       memsync_pin;
  logic [1:0] ratio_pin;

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
    end else begin
      meta_ff <= {RESET_REQUEST_N_IN, BOOT_MODE_IN, MEM_SYNC_STRAP_IN, PCI_RATIO_STRAP_IN};
      sync_ff <= meta_ff;
    end
  end

  assign {req_n, boot_pin, memsync_pin, ratio_pin} = sync_ff;

  // phase, hold counter and straps
  rps_phase_e             phase_ff;
  rps_phase_e             nxt_phase;
  logic [`RPS_CNT_W-1:0]  cnt_ff;
  logic [`RPS_CNT_W-1:0]  nxt_cnt;
  logic [1:0]             boot_ff;
  logic [1:0]             nxt_boot;
  logic                   memsync_ff;
  logic                   nxt_memsync;
  logic [1:0]             ratio_ff;
  logic [1:0]             nxt_ratio;

  localparam logic [`RPS_CNT_W-1:0] HOLD_LAST = `RPS_CNT_W'(`RPS_HOLD_CYCLES - 1);

  always_comb begin
    nxt_phase   = phase_ff;
    nxt_cnt     = cnt_ff;
    nxt_boot    = boot_ff;
    nxt_memsync = memsync_ff;
    nxt_ratio   = ratio_ff;
    case (phase_ff)
      PH_IN_RESET: begin
        // straps follow the pins while input reset is held
        nxt_boot    = boot_pin;
        nxt_memsync = memsync_pin;
        nxt_ratio   = ratio_pin;
        nxt_cnt     = '0;
        if (req_n) begin
          nxt_phase = PH_HOLD;
        end
      end
      PH_HOLD: begin
        if (cnt_ff == HOLD_LAST) begin
          nxt_phase = PH_INIT;
        end else begin
          nxt_cnt = cnt_ff + `RPS_CNT_W'(1);
        end
      end
      PH_INIT: begin
        if (MEM_INIT_DONE_IN) begin
          nxt_phase = PH_FETCH;
        end
      end
      PH_FETCH: begin
        if (PREFETCH_ACK_IN) begin
          nxt_phase = PH_RUN;
        end
      end
      PH_RUN: begin
        nxt_phase = PH_RUN;
      end
      default: begin
        nxt_phase = PH_IN_RESET;
      end
    endcase
    if (!req_n) begin
      nxt_phase = PH_IN_RESET;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      phase_ff   <= PH_IN_RESET;
      cnt_ff     <= '0;
      boot_ff    <= 2'h0;
      memsync_ff <= 1'b0;
      ratio_ff   <= 2'h0;
    end else begin
      phase_ff   <= nxt_phase;
      cnt_ff     <= nxt_cnt;
      boot_ff    <= nxt_boot;
      memsync_ff <= nxt_memsync;
      ratio_ff   <= nxt_ratio;
    end
  end

  // registered outputs, decoded from the next phase and the next boot strap
  rps_pins_s  pins_ff;
  rps_pins_s  nxt_pins;
  logic       rst_n_ff;
  logic       nxt_rst_n;
  logic       init_ff;
  logic       nxt_init;
  logic       fetch_ff;
  logic       nxt_fetch;
  rps_bus_e   bus_ff;
  rps_bus_e   nxt_bus;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;

  always_comb begin
    nxt_pins.io_read_n    = 2'h3;
    nxt_pins.io_write_n   = 2'h3;
    nxt_pins.flash_n      = 4'hF;
    // defined levels even where input reset allows undefined
    nxt_pins.drive_select = 4'h0;
    nxt_pins.isa_cmd_n    = 4'hF;
    nxt_pins.isa_side_select = (nxt_phase == PH_IN_RESET) || (nxt_phase == PH_HOLD);
    nxt_rst_n = !((nxt_phase == PH_IN_RESET) || (nxt_phase == PH_HOLD));
    nxt_init  = (nxt_phase == PH_INIT);
    nxt_fetch = (nxt_phase == PH_FETCH);
    nxt_bus   = boot_bus(nxt_boot);
    nxt_addr  = `RPS_BOOT_ADDR;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      pins_ff  <= '{isa_side_select: 1'b1, drive_select: 4'h0, io_read_n: 2'h3,
                    io_write_n: 2'h3, isa_cmd_n: 4'hF, flash_n: 4'hF};
      rst_n_ff <= 1'b0;
      init_ff  <= 1'b0;
      fetch_ff <= 1'b0;
      bus_ff   <= BUS_PCI;
      addr_ff  <= `RPS_BOOT_ADDR;
    end else begin
      pins_ff  <= nxt_pins;
      rst_n_ff <= nxt_rst_n;
      init_ff  <= nxt_init;
      fetch_ff <= nxt_fetch;
      bus_ff   <= nxt_bus;
      addr_ff  <= nxt_addr;
    end
  end

  assign PINS_OUT           = pins_ff;
  assign SYSTEM_RESET_N_OUT = rst_n_ff;
  assign MEM_INIT_REQ_OUT   = init_ff;
  assign PREFETCH_REQ_OUT   = fetch_ff;
  assign PREFETCH_BUS_OUT   = bus_ff;
  assign PREFETCH_ADDR_OUT  = addr_ff;

  rps_clkgen u_clkgen (
    .clk_in               (REF_CLK_IN),
    .srst_in              (SRST_IN),
    .mem_sync_in          (memsync_ff),
    .ratio_in             (ratio_ff),
    .mem_clk_in           (MEM_CLOCK_IN),
    .memory_clock_out     (MEMORY_CLOCK_OUT),
    .pci_clock_output_out (PCI_CLOCK_OUTPUT_OUT)
  );

  a_reset_out_phase: assert property (
    (phase_ff == PH_IN_RESET || phase_ff == PH_HOLD) |-> !SYSTEM_RESET_N_OUT)
    else $error("system reset released during reset phases");

  a_hold_then_release: assert property (
    (phase_ff == PH_HOLD && cnt_ff == HOLD_LAST && req_n) |=> SYSTEM_RESET_N_OUT)
    else $error("system reset not released after hold");

  a_drive_select_low: assert property (
    (phase_ff == PH_HOLD) |-> (PINS_OUT.drive_select == 4'h0))
    else $error("drive selects not low in hold phase");

  a_ide_strobes_idle: assert property (
    (!SYSTEM_RESET_N_OUT) |-> (PINS_OUT.io_read_n == 2'h3 && PINS_OUT.io_write_n == 2'h3))
    else $error("ide strobes active during reset");

  a_isa_cmd_idle: assert property (
    (phase_ff == PH_HOLD) |-> (PINS_OUT.isa_cmd_n == 4'hF))
    else $error("isa strobes active in hold phase");

  a_flash_idle: assert property (
    (!SYSTEM_RESET_N_OUT) |-> (PINS_OUT.flash_n == 4'hF))
    else $error("flash select active during reset");

  a_fetch_bus_pci: assert property (
    (PREFETCH_REQ_OUT && boot_ff == `RPS_BOOT_PCI) |-> (PREFETCH_BUS_OUT == BUS_PCI))
    else $error("prefetch not on pci bus");

  a_fetch_bus_isa: assert property (
    (PREFETCH_REQ_OUT && boot_ff[1]) |-> (PREFETCH_BUS_OUT == BUS_ISA))
    else $error("prefetch not on isa bus");

  a_fetch_address: assert property (
    $rose(PREFETCH_REQ_OUT) |-> (PREFETCH_ADDR_OUT == 24'hFFFFF0))
    else $error("prefetch address wrong");

  a_init_before_fetch: assert property (
    $rose(PREFETCH_REQ_OUT) |-> $past(MEM_INIT_REQ_OUT) && $past(MEM_INIT_DONE_IN))
    else $error("prefetch began without memory init");

  a_side_select: assert property (
    $rose(SYSTEM_RESET_N_OUT) |-> !PINS_OUT.isa_side_select && $past(PINS_OUT.isa_side_select))
    else $error("isa side select wrong at reset release");

endmodule

// *** sim/rps_partner.sv ***
`timescale 1ns/100ps

module rps_partner (
  // clock
  input  wire logic       clk_in,
  // requests from the block
  input  wire logic       init_req_in,
  input  wire logic       pf_req_in,
  // answer delay in cycles
  input  wire logic [2:0] delay_in,
  // answers
  output logic            init_done_out,
  output logic            pf_ack_out
);
  logic [2:0] cnt_ff;
  logic [1:0] req_ff;

  // the wait restarts whenever the request pattern changes
  always_ff @(posedge clk_in) begin
    req_ff <= {init_req_in, pf_req_in};
    if ({init_req_in, pf_req_in} != req_ff) begin
      cnt_ff <= 3'h0;
    end else if (cnt_ff != 3'h7) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  assign init_done_out = init_req_in && ({init_req_in, pf_req_in} == req_ff) && (cnt_ff >= delay_in);
  assign pf_ack_out    = pf_req_in && ({init_req_in, pf_req_in} == req_ff) && (cnt_ff >= delay_in);
endmodule

// *** sim/rps_top_tb.sv ***
`timescale 1ns/100ps

module rps_top_tb;
  import rps_pkg::*;
  logic       clk = 1'b0, srst = 1'b1, rst_req_n = 1'b0, mem_sync = 1'b0, mem_clk = 1'b0;
  logic [1:0] boot = 2'h0, ratio = 2'h0;
  logic [2:0] dly = 3'h0;
  logic       init_req, init_done, pf_req, pf_ack, sys_rst_n, mclk, pclk;
  rps_bus_e   pf_bus;
  logic [23:0] pf_addr;
  rps_pins_s  pins;
  int         errors = 0, n_tests = 0, k;

  initial forever #4 clk = ~clk;
  initial forever #5.3 mem_clk = ~mem_clk;

  rps_top u_dut (
    .REF_CLK_IN(clk), .SRST_IN(srst), .RESET_REQUEST_N_IN(rst_req_n),
    .BOOT_MODE_IN(boot), .MEM_SYNC_STRAP_IN(mem_sync), .PCI_RATIO_STRAP_IN(ratio),
    .MEM_CLOCK_IN(mem_clk), .MEM_INIT_REQ_OUT(init_req), .MEM_INIT_DONE_IN(init_done),
    .PREFETCH_REQ_OUT(pf_req), .PREFETCH_BUS_OUT(pf_bus), .PREFETCH_ADDR_OUT(pf_addr),
    .PREFETCH_ACK_IN(pf_ack), .SYSTEM_RESET_N_OUT(sys_rst_n), .PINS_OUT(pins),
    .MEMORY_CLOCK_OUT(mclk), .PCI_CLOCK_OUTPUT_OUT(pclk));

  rps_partner u_partner (
    .clk_in(clk), .init_req_in(init_req), .pf_req_in(pf_req), .delay_in(dly),
    .init_done_out(init_done), .pf_ack_out(pf_ack));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [1:0] exp_bus(input logic [1:0] m);
    return (m == `RPS_BOOT_PCI) ? BUS_PCI : (m == `RPS_BOOT_LOCAL) ? BUS_LOCAL : BUS_ISA;
  endfunction

  function automatic int exp_div(input logic [1:0] r);
    return (r == `RPS_RATIO_DIV2) ? 2 : (r == `RPS_RATIO_DIV4) ? 4 : 3;
  endfunction

  // waits at most lim cycles for a level on a design output
  task automatic wait_for(input string what, ref logic sig, input logic lvl, input int lim);
    int i;
    i = 0;
    while (sig !== lvl && i < lim) begin
      @(negedge clk);
      i++;
    end
    check(what, {31'h0, sig}, {31'h0, lvl});
  endtask

  task automatic measure_pci(input logic [1:0] r);
    int n;
    n = 0;
    wait_for("pci_low", pclk, 1'b0, 10);
    wait_for("pci_rise", pclk, 1'b1, 10);
    while (pclk === 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check("pci_high_cycles", n, exp_div(r) / 2);
    while (pclk === 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check("pci_period", n, exp_div(r));
  endtask

  task automatic boot_run(input logic [1:0] m, input logic [1:0] r, input logic s);
    @(negedge clk);
    rst_req_n = 1'b0;
    boot = m;
    ratio = r;
    mem_sync = s;
    dly = 3'($urandom_range(0, 6));
    repeat (6) @(negedge clk);
    check("sys_rst_in", sys_rst_n, 0);
    check("io_strobes_in", {pins.io_read_n, pins.io_write_n}, 4'hF);
    check("flash_in", pins.flash_n, 4'hF);
    check("side_sel_in", pins.isa_side_select, 1);
    rst_req_n = 1'b1;
    repeat (10) @(negedge clk);
    check("sys_rst_hold", sys_rst_n, 0);
    check("drive_sel_hold", pins.drive_select, 4'h0);
    check("isa_cmd_hold", pins.isa_cmd_n, 4'hF);
    check("io_strobes_hold", {pins.io_read_n, pins.io_write_n}, 4'hF);
    check("side_sel_hold", pins.isa_side_select, 1);
    wait_for("sys_rst_release", sys_rst_n, 1'b1, 150);
    check("side_sel_run", pins.isa_side_select, 0);
    check("init_first", {init_req, pf_req}, 2'b10);
    wait_for("prefetch_req", pf_req, 1'b1, 20);
    check("init_done_first", init_req, 0);
    check("prefetch_bus", pf_bus, exp_bus(m));
    check("prefetch_addr", pf_addr, 24'hFFFFF0);
    check("flash_run", pins.flash_n, 4'hF);
    wait_for("prefetch_done", pf_req, 1'b0, 20);
    // sample the selected source just after its own edges, never on one
    if (s) begin
      @(posedge clk);
    end else begin
      @(posedge mem_clk);
    end
    #1;
    check("mem_clock_hi", mclk, 1);
    if (s) begin
      @(negedge clk);
    end else begin
      @(negedge mem_clk);
    end
    #1;
    check("mem_clock", mclk, 0);
    @(negedge clk);
    measure_pci(r);
    $display("test boot %0d ratio %0d sync %0d done", m, r, s);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    summarize();
  end

  initial begin
    void'($urandom(88205));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    for (k = 0; k < 4; k++) begin
      boot_run(k[1:0], k[1:0], k[0]);
    end
    for (k = 0; k < 6; k++) begin
      boot_run(2'($urandom), 2'($urandom), 1'($urandom));
    end
    // reset pin pulled low in mid hold must restart the whole sequence
    @(negedge clk);
    rst_req_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_req_n = 1'b1;
    repeat (40) @(negedge clk);
    rst_req_n = 1'b0;
    // long enough that an unrestarted hold would already have released
    repeat (100) @(negedge clk);
    check("side_sel_abort", pins.isa_side_select, 1);
    check("sys_rst_abort", sys_rst_n, 0);
    $display("test reset abort done");
    boot_run(2'h1, 2'h1, 1'b0);
    // synchronous reset in mid run
    srst = 1'b1;
    @(negedge clk);
    check("sys_rst_srst", sys_rst_n, 0);
    check("side_sel_srst", pins.isa_side_select, 1);
    check("req_srst", {init_req, pf_req}, 2'b00);
    srst = 1'b0;
    $display("test sync reset done");
    summarize();
  end
endmodule
